/* File: common/svm_pkg.sv */
// Purpose: Shared constants and types of the supply monitor response block.
// Assumes: Single 40 MHz clock domain, 16-bit register data.
// Notes: Channel indices order the comparator vector everywhere.
package svm_pkg;

  // ****************************************************************
  // Comparator channels
  // ****************************************************************
  localparam int NCH = 12;
  localparam int CH_XCVR_UV = 0;
  localparam int CH_XCVR_OV = 1;
  localparam int CH_IO_UV = 2;
  localparam int CH_IO_OV = 3;
  localparam int CH_CORE_UV = 4;
  localparam int CH_CORE_OV = 5;
  localparam int CH_SENS_UV = 6;
  localparam int CH_SENS_OV = 7;
  localparam int CH_CPH_OV = 8;
  localparam int CH_CPL_UV = 9;
  localparam int CH_CPL_OV = 10;
  localparam int CH_ANA_OUT = 11;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_MHZ = 40;
  localparam int FILT_TIME_NS = 10000;
  localparam int FILT_CYCLES = (FILT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFF_STAT_FIRST = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT_SECOND = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SAFETY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h18;

  // Status bit positions.
  localparam int B1_ANA = 2;
  localparam int B1_CPL_UV = 3;
  localparam int B1_CPL_OV = 4;
  localparam int B1_CPH_OV = 5;
  localparam int B2_CORE_UV = 0;
  localparam int B2_CORE_OV = 1;
  localparam int B2_IO_UV = 2;
  localparam int B2_IO_OV = 3;
  localparam int B2_XCVR_UV = 4;
  localparam int B2_XCVR_OV = 5;
  localparam int BS_SENS_OV = 4;
  localparam int BS_SENS_UV = 5;

  // Configuration bit positions.
  localparam int CFG_CORE_UNMASK = 0;
  localparam int CFG_ENABLE_DRIVER_OUT_REQ = 1;

  // Reset values.
  localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h0001;
  localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 16'h0000;

  // ****************************************************************
  // Device state
  // ****************************************************************
  typedef enum logic [1:0] {
    SVM_ACTIVE,
    SVM_RESET,
    SVM_STANDBY
  } svm_state_t;

endpackage

/* File: common/svm_cmp_if.sv */
// Purpose: Carries raw and filtered comparator vectors between modules.
// Assumes: Raw comparator outputs are asynchronous to mclk.
// Notes: The filter drives the filtered vector.
`timescale 1ns/1ps
interface svm_cmp_if;
  import svm_pkg::*;
  logic [NCH-1:0] raw;
  logic [NCH-1:0] filtered;

  modport filter (input raw, output filtered);
  modport core (output raw, input filtered);
endinterface

/* File: core/svm_glitch_filter.sv */
// Purpose: Synchronise and deglitch every comparator channel.
// Assumes: Raw inputs come from the analog domain, unrelated to mclk.
// Notes: Output changes only after the input held steady FILT_LEN cycles.
`timescale 1ns/1ps
module svm_glitch_filter
  import svm_pkg::*;
#(
  parameter int FILT_LEN = FILT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Comparator vectors
  svm_cmp_if.filter cmp
);

  localparam int CW = $clog2(FILT_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_LEN - 1);

  logic [NCH-1:0] syncA;
  logic [NCH-1:0] syncB;
  logic [NCH-1:0] level;
  logic [CW-1:0] count [NCH];

  // ****************************************************************
  // Two-stage synchroniser
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= cmp.raw;
      syncB <= syncA;
    end
  end

  // ****************************************************************
  // Per-channel persistence counters
  // ****************************************************************
  // Both edges are filtered so a flag neither sets nor clears on a spike.
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        count[i] <= '0;
        level[i] <= 1'b0;
      end else if (syncB[i] == level[i]) begin
        count[i] <= '0; // [R13]
      end else if (count[i] == LAST) begin
        count[i] <= '0;
        level[i] <= syncB[i]; // [R13]
      end else begin
        count[i] <= count[i] + CW'(1);
      end
    end
  end

  assign cmp.filtered = level;

endmodule

/* File: core/svm_fault_response.sv */
// Purpose: Supply monitor fault response, status flags and register port.
// Assumes: Comparator outputs are raw; one 40 MHz clock; MCU reads flags.
// Notes: Function
// Function
// R1: Transceiver rail undervoltage sets second status bit 4 only.
// R2: Transceiver rail overvoltage sets second status bit 5, enable low.
// R3: I/O rail undervoltage sets second bit 2, RESET, reset and enable low.
// R4: I/O rail overvoltage sets second bit 3, enable low, state unchanged.
// R5: Core undervoltage sets second bit 0; if unmasked RESET, outputs low.
// R6: Core overvoltage sets second bit 1; if unmasked enable output low.
// R7: Sensor rail sets safety bit 5 undervoltage, bit 4 overvoltage.
// R8: High pump overvoltage sets first bit 5, STANDBY, outputs low.
// R9: Low pump undervoltage sets first bit 3, nothing else changes.
// R10: Low pump overvoltage sets first bit 4, stops regulators, STANDBY.
// R11: Analog monitor supply fault sets first bit 2, POR, STANDBY.
// R12: Status flags read 1 while out of band, 0 while in band.
// R13: Comparator glitches are filtered before any flag is set.
// R14: STANDBY beats RESET beats flag-only; all flags still set.
`timescale 1ns/1ps
module svm_fault_response
  import svm_pkg::*;
#(
  parameter int FILT_LEN = FILT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Raw comparator outputs
  input wire logic [NCH-1:0] cmpRaw,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  // Device outputs
  output logic mcuResetOut_n,
  output logic enableDriverOut,
  output logic power_on_reset_n,
  output logic regulatorStop,
  output svm_state_t deviceState,
  output logic irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic anyOf(input logic [NCH-1:0] v,
                                 input logic [NCH-1:0] sel);
    anyOf = |(v & sel);
  endfunction

  function automatic logic [NCH-1:0] chBit(input int idx);
    chBit = NCH'(1) << idx;
  endfunction

  // ****************************************************************
  // Glitch filter
  // ****************************************************************
  svm_cmp_if cmp ();
  assign cmp.raw = cmpRaw;

  svm_glitch_filter #(
    .FILT_LEN(FILT_LEN)
  ) u_filter (
    .mclk(mclk),
    .reset_n(reset_n),
    .cmp(cmp.filter)
  );

  logic [NCH-1:0] flt;
  assign flt = cmp.filtered; // [R13]

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [DATA_W-1:0] cfgBits;
  logic [DATA_W-1:0] irqMask;
  logic [NCH-1:0] irqStat;
  logic [NCH-1:0] fltPrev;
  logic coreUnmask;
  logic endrvReq;

  assign coreUnmask = cfgBits[CFG_CORE_UNMASK];
  assign endrvReq = cfgBits[CFG_ENABLE_DRIVER_OUT_REQ];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfgBits <= CONFIG_RESET;
    end else if (regWr && regAddr == OFF_CONFIG) begin
      cfgBits <= regWrData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irqMask <= IRQ_MASK_RESET;
    end else if (regWr && regAddr == OFF_IRQ_MASK) begin
      irqMask <= regWrData;
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Status flags follow the filtered comparator levels live.
  logic [DATA_W-1:0] statFirst;
  logic [DATA_W-1:0] statSecond;
  logic [DATA_W-1:0] statSafety;

  always_comb begin
    statFirst = '0;
    statFirst[B1_ANA] = flt[CH_ANA_OUT]; // [R11] [R12]
    statFirst[B1_CPL_UV] = flt[CH_CPL_UV]; // [R9]
    statFirst[B1_CPL_OV] = flt[CH_CPL_OV]; // [R10]
    statFirst[B1_CPH_OV] = flt[CH_CPH_OV]; // [R8]
  end

  always_comb begin
    statSecond = '0;
    statSecond[B2_CORE_UV] = flt[CH_CORE_UV]; // [R5] [R12]
    statSecond[B2_CORE_OV] = flt[CH_CORE_OV]; // [R6]
    statSecond[B2_IO_UV] = flt[CH_IO_UV]; // [R3]
    statSecond[B2_IO_OV] = flt[CH_IO_OV]; // [R4]
    statSecond[B2_XCVR_UV] = flt[CH_XCVR_UV]; // [R1]
    statSecond[B2_XCVR_OV] = flt[CH_XCVR_OV]; // [R2]
  end

  always_comb begin
    statSafety = '0;
    statSafety[BS_SENS_UV] = flt[CH_SENS_UV]; // [R7] [R12]
    statSafety[BS_SENS_OV] = flt[CH_SENS_OV]; // [R7]
  end

  // ****************************************************************
  // Fault causes
  // ****************************************************************
  // Channels that only flag (transceiver undervoltage, low pump
  // undervoltage, sensor rail) appear in no cause mask.
  logic [NCH-1:0] standbySel;
  logic [NCH-1:0] resetSel;
  logic [NCH-1:0] endrvSel;
  logic standbyCause;
  logic resetCause;
  logic endrvOff;

  always_comb begin
    standbySel = chBit(CH_CPH_OV) | chBit(CH_CPL_OV)
                 | chBit(CH_ANA_OUT); // [R8] [R10] [R11]
    resetSel = chBit(CH_IO_UV); // [R3]
    if (coreUnmask) begin
      resetSel = resetSel | chBit(CH_CORE_UV); // [R5]
    end
    endrvSel = standbySel | resetSel | chBit(CH_XCVR_OV)
               | chBit(CH_IO_OV); // [R2] [R4]
    if (coreUnmask) begin
      endrvSel = endrvSel | chBit(CH_CORE_OV); // [R6]
    end
  end

  assign standbyCause = anyOf(flt, standbySel);
  assign resetCause = anyOf(flt, resetSel);
  assign endrvOff = anyOf(flt, endrvSel);

  // ****************************************************************
  // Device state
  // ****************************************************************
  svm_state_t next_state;

  always_comb begin
    case ({standbyCause, resetCause})
      2'b10, 2'b11: next_state = SVM_STANDBY; // [R14]
      2'b01: next_state = SVM_RESET; // [R14] [R3] [R5]
      2'b00: next_state = SVM_ACTIVE;
      default: next_state = SVM_STANDBY;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      deviceState <= SVM_STANDBY;
    end else begin
      deviceState <= next_state; // [R8] [R10] [R11]
    end
  end

  // ****************************************************************
  // Output pins
  // ****************************************************************
  // Outputs are registered so the pins never see decode glitches.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mcuResetOut_n <= 1'b0;
    end else begin
      mcuResetOut_n <= !(standbyCause || resetCause); // [R14] [R3] [R8]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enableDriverOut <= 1'b0;
    end else begin
      enableDriverOut <= endrvReq && !endrvOff; // [R2] [R4] [R6] [R10]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regulatorStop <= 1'b0;
      power_on_reset_n <= 1'b0;
    end else begin
      regulatorStop <= flt[CH_CPL_OV]; // [R10]
      power_on_reset_n <= !flt[CH_ANA_OUT]; // [R11]
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // A new fault in the cycle of the clearing read stays pending.
  logic [NCH-1:0] rise;
  logic irqClr;

  assign rise = flt & ~fltPrev;
  assign irqClr = regRd && regAddr == OFF_IRQ_STAT;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fltPrev <= '0;
    end else begin
      fltPrev <= flt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat <= '0;
    end else if (irqClr) begin
      irqStat <= rise;
    end else begin
      irqStat <= irqStat | rise;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= anyOf(irqStat, irqMask[NCH-1:0]);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= '0;
    end else if (regRd) begin
      case (regAddr)
        OFF_STAT_FIRST: regRdData <= statFirst;
        OFF_STAT_SECOND: regRdData <= statSecond;
        OFF_SAFETY: regRdData <= statSafety;
        OFF_CONFIG: regRdData <= cfgBits;
        OFF_IRQ_STAT: regRdData <= DATA_W'(irqStat);
        OFF_IRQ_MASK: regRdData <= irqMask;
        OFF_STATE: regRdData <= DATA_W'(deviceState);
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule

/* File: bench/svm_fault_response_sva.sv */
// Purpose: Port-level checks of the supply monitor fault response.
// Assumes: A filter length of at least 4 cycles.
// Notes: Bound into every instance of svm_fault_response.
`timescale 1ns/1ps
module svm_fault_response_sva
  import svm_pkg::*;
#(
  parameter int FILT_LEN = FILT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Inputs
  input wire logic [NCH-1:0] cmpRaw,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  // Outputs
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic mcuResetOut_n,
  input wire logic enableDriverOut,
  input wire logic power_on_reset_n,
  input wire logic regulatorStop,
  input wire svm_state_t deviceState,
  input wire logic irq
);
  // ****************************************************************
  // Quiet time counter
  // ****************************************************************
  // Saturates so the count never wraps; the quiet check then holds on.
  int quietCnt;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      quietCnt <= 0;
    end else if (cmpRaw != '0) begin
      quietCnt <= 0;
    end else if (quietCnt < FILT_LEN + 6) begin
      quietCnt <= quietCnt + 1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_enter_standby;
    deviceState != SVM_STANDBY ##1 deviceState == SVM_STANDBY;
  endsequence
  sequence s_enter_reset;
    deviceState == SVM_ACTIVE ##1 deviceState == SVM_RESET;
  endsequence

  property p_standby_out;
    deviceState == SVM_STANDBY |-> !mcuResetOut_n && !enableDriverOut;
  endproperty
  a_standby_out: assert property (p_standby_out)
    else $error("outputs high in standby");
  property p_reset_out;
    deviceState == SVM_RESET |-> !mcuResetOut_n && !enableDriverOut;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs high in reset state");
  property p_por;
    !power_on_reset_n |-> deviceState == SVM_STANDBY;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on reset outside standby");
  property p_reg_stop;
    regulatorStop |-> deviceState == SVM_STANDBY;
  endproperty
  a_reg_stop: assert property (p_reg_stop)
    else $error("regulators stopped outside standby");
  property p_standby_cause;
    s_enter_standby |->
      $past(cmpRaw[CH_CPH_OV] | cmpRaw[CH_CPL_OV] | cmpRaw[CH_ANA_OUT], 5);
  endproperty
  a_standby_cause: assert property (p_standby_cause)
    else $error("standby without a steady cause");
  property p_reset_cause;
    s_enter_reset |-> $past(cmpRaw[CH_IO_UV] | cmpRaw[CH_CORE_UV], 5);
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("reset state without a steady cause");
  property p_quiet;
    quietCnt == FILT_LEN + 6 |-> mcuResetOut_n && power_on_reset_n &&
      !regulatorStop && deviceState == SVM_ACTIVE;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("fault response without a fault");
  property p_rd_idle;
    !regRd |=> regRdData == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the read cycle");
endmodule

bind svm_fault_response svm_fault_response_sva #(.FILT_LEN(FILT_LEN)) u_sva (
  .mclk(mclk), .reset_n(reset_n), .cmpRaw(cmpRaw), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .mcuResetOut_n(mcuResetOut_n),
  .enableDriverOut(enableDriverOut), .power_on_reset_n(power_on_reset_n),
  .regulatorStop(regulatorStop), .deviceState(deviceState), .irq(irq));

/* File: bench/svm_mcu_model.sv */
// Purpose: Microcontroller that reads and writes the monitor registers.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Signals change by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module svm_mcu_model
  import svm_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [DATA_W-1:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // The slave never stalls, so data are taken one edge after the strobe.
  task automatic rd(input logic [ADDR_W-1:0] a,
      output logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    d = regRdData;
  endtask
endmodule

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench of the supply monitor fault response.
// Assumes: Filter shortened to 4 cycles; clock 40 MHz.
// Notes: Flags are live, so each fault is checked while it is held.
`timescale 1ns/1ps
module tb_top;
  import svm_pkg::*;
  localparam int FL = 4;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [NCH-1:0] cmpRaw = '0;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [DATA_W-1:0] regRdData;
  logic mcuResetOut_n;
  logic enableDriverOut;
  logic power_on_reset_n;
  logic regulatorStop;
  svm_state_t deviceState;
  logic irq;
  int nMismatch = 0;
  int testsRun = 0;

  always #12.5 mclk = ~mclk;

  svm_fault_response #(.FILT_LEN(FL)) dut (
    .mclk(mclk), .reset_n(reset_n), .cmpRaw(cmpRaw), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .mcuResetOut_n(mcuResetOut_n),
    .enableDriverOut(enableDriverOut), .power_on_reset_n(power_on_reset_n),
    .regulatorStop(regulatorStop), .deviceState(deviceState), .irq(irq));
  svm_mcu_model mcu (.mclk(mclk), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData));

  task automatic chk(input logic [DATA_W-1:0] got, exp, input string what);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic chkRd(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    mcu.rd(a, d);
    chk(d, exp, "read");
  endtask

  // Outputs are {reset out, enable, regulator stop, power-on reset}.
  task automatic fault(input logic [NCH-1:0] f, input logic [5:0] s1, s2,
      ss, input svm_state_t st, input logic [3:0] o);
    @(posedge mclk);
    cmpRaw <= f;
    repeat (FL + 5) @(posedge mclk);
    chk({14'h0, deviceState}, {14'h0, st}, "state");
    chk({12'h0, mcuResetOut_n, enableDriverOut, regulatorStop,
      power_on_reset_n}, {12'h0, o}, "outputs");
    chkRd(OFF_STAT_FIRST, {10'h0, s1});
    chkRd(OFF_STAT_SECOND, {10'h0, s2});
    chkRd(OFF_SAFETY, {10'h0, ss});
    cmpRaw <= '0;
    for (int i = 0; i < 40 && deviceState !== SVM_ACTIVE; i++) begin
      @(posedge mclk);
    end
    repeat (FL + 5) @(posedge mclk);
    chk({14'h0, deviceState}, {14'h0, SVM_ACTIVE}, "state after");
    if (deviceState !== SVM_ACTIVE) conclude();
    chkRd(OFF_STAT_FIRST, 16'h0000);
    chkRd(OFF_STAT_SECOND, 16'h0000);
  endtask

  task automatic regAccess();
    chkRd(OFF_CONFIG, CONFIG_RESET);
    chkRd(OFF_IRQ_MASK, IRQ_MASK_RESET);
    chkRd(8'h1c, 16'h0000);
    mcu.wr(OFF_STATE, 16'h0002);
    chkRd(OFF_STATE, 16'h0000);
    chk({15'h0, enableDriverOut}, 16'h0000, "enable idle");
    mcu.wr(OFF_CONFIG, 16'h0003);
    chkRd(OFF_CONFIG, 16'h0003);
    chk({15'h0, enableDriverOut}, 16'h0001, "enable on");
  endtask

  task automatic railFaults();
    fault(12'h001, 6'h00, 6'h10, 6'h00, SVM_ACTIVE, 4'hd);
    fault(12'h002, 6'h00, 6'h20, 6'h00, SVM_ACTIVE, 4'h9);
    fault(12'h004, 6'h00, 6'h04, 6'h00, SVM_RESET, 4'h1);
    fault(12'h008, 6'h00, 6'h08, 6'h00, SVM_ACTIVE, 4'h9);
    fault(12'h010, 6'h00, 6'h01, 6'h00, SVM_RESET, 4'h1);
    fault(12'h020, 6'h00, 6'h02, 6'h00, SVM_ACTIVE, 4'h9);
    fault(12'h040, 6'h00, 6'h00, 6'h20, SVM_ACTIVE, 4'hd);
    fault(12'h080, 6'h00, 6'h00, 6'h10, SVM_ACTIVE, 4'hd);
    fault(12'h100, 6'h20, 6'h00, 6'h00, SVM_STANDBY, 4'h1);
    fault(12'h200, 6'h08, 6'h00, 6'h00, SVM_ACTIVE, 4'hd);
    fault(12'h400, 6'h10, 6'h00, 6'h00, SVM_STANDBY, 4'h3);
    fault(12'h800, 6'h04, 6'h00, 6'h00, SVM_STANDBY, 4'h0);
    fault(12'h114, 6'h20, 6'h05, 6'h00, SVM_STANDBY, 4'h1);
    fault(12'h01c, 6'h00, 6'h0d, 6'h00, SVM_RESET, 4'h1);
  endtask

  task automatic maskedCore();
    mcu.wr(OFF_CONFIG, 16'h0002);
    fault(12'h010, 6'h00, 6'h01, 6'h00, SVM_ACTIVE, 4'hd);
    fault(12'h020, 6'h00, 6'h02, 6'h00, SVM_ACTIVE, 4'hd);
    mcu.wr(OFF_CONFIG, 16'h0003);
  endtask

  // A pulse one cycle shorter than the filter must leave no trace.
  task automatic glitchReject();
    logic sawLow;
    sawLow = 1'b0;
    @(posedge mclk);
    cmpRaw <= 12'h104;
    repeat (FL - 1) @(posedge mclk);
    cmpRaw <= '0;
    repeat (FL + 8) begin
      @(posedge mclk);
      sawLow = sawLow | !mcuResetOut_n;
    end
    chk({15'h0, sawLow}, 16'h0000, "glitch");
    chkRd(OFF_STAT_SECOND, 16'h0000);
    chkRd(OFF_STAT_FIRST, 16'h0000);
  endtask

  task automatic irqFlow();
    int i;
    // Every channel has faulted in earlier scenarios; clear before arming.
    chkRd(OFF_IRQ_STAT, 16'h0fff);
    chkRd(OFF_IRQ_STAT, 16'h0000);
    mcu.wr(OFF_IRQ_MASK, 16'h0200);
    @(posedge mclk);
    cmpRaw <= 12'h201;
    for (i = 0; i < FL + 12 && irq !== 1'b1; i++) begin
      @(posedge mclk);
    end
    chk({15'h0, irq}, 16'h0001, "irq raised");
    if (irq !== 1'b1) conclude();
    chkRd(OFF_IRQ_STAT, 16'h0201);
    repeat (2) @(posedge mclk);
    chk({15'h0, irq}, 16'h0000, "irq cleared");
    chkRd(OFF_IRQ_STAT, 16'h0000);
    cmpRaw <= '0;
    repeat (FL + 6) @(posedge mclk);
    mcu.wr(OFF_IRQ_MASK, 16'h0000);
    cmpRaw <= 12'h200;
    repeat (FL + 8) @(posedge mclk);
    chk({15'h0, irq}, 16'h0000, "irq masked");
    chkRd(OFF_IRQ_STAT, 16'h0200);
    cmpRaw <= '0;
    repeat (FL + 6) @(posedge mclk);
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    regAccess();
    railFaults();
    maskedCore();
    glitchReject();
    irqFlow();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    nMismatch++;
    conclude();
  end
endmodule
